// ---- src/cidr_regs.sv ----
`timescale 1ns/1ps
module cidr_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_l2_built,
  input wire logic cluster_l3_built
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] selector;  // software cache selection
    logic [31:0] rdata;  // registered read data
    logic err;  // registered error answer
    cidr_pkg::cidr_phase_t phase;  // tracks access phase
  } cidr_state_t;

  cidr_state_t st_r;
  cidr_state_t st_nxt;
  cidr_pkg::cidr_cfg_t cfg;
  cidr_pkg::cidr_size_t size_word;
  cidr_pkg::cidr_level_t level_word;
  logic size_valid;
  logic setup;  // setup cycle of a transfer

  assign cfg.core_l2 = core_l2_built;
  assign cfg.cluster_l3 = cluster_l3_built;

  // ------------------------------------------------------------
  // identification sources
  // ------------------------------------------------------------
  cidr_size_lut u_size (
    .sel(st_r.selector),
    .cfg(cfg),
    .word(size_word),
    .valid(size_valid)
  );

  cidr_level_gen u_level (
    .cfg(cfg),
    .word(level_word)
  );

  // ------------------------------------------------------------
  // apb slave: decode in setup, answer in access with no wait
  // ------------------------------------------------------------
  assign setup = psel && !penable;

  // read data is captured at setup so it is stable through access
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = setup ? cidr_pkg::PH_ACCESS : cidr_pkg::PH_IDLE;
    if (setup) begin
      st_nxt.err = 1'b0;
      st_nxt.rdata = '0;
      case (paddr)
        cidr_pkg::OFS_SELECTOR: begin
          st_nxt.rdata = {28'h0000000, st_r.selector};
        end
        cidr_pkg::OFS_SIZE: begin
          st_nxt.rdata = size_word;
        end
        cidr_pkg::OFS_LEVEL_LO: begin
          st_nxt.rdata = level_word[31:0];
        end
        cidr_pkg::OFS_LEVEL_HI: begin
          st_nxt.rdata = level_word[63:32];
        end
        cidr_pkg::OFS_AUX_FAULT: begin
          st_nxt.rdata = '0;
        end
        cidr_pkg::OFS_CONFIG: begin
          st_nxt.rdata = {29'h00000000, size_valid, cfg};
        end
        default: begin
          st_nxt.err = 1'b1;  // unmapped address
        end
      endcase
      if (pwrite) begin
        st_nxt.rdata = '0;  // writes return no data
      end
    end
    // selector lands only at the completing access edge, as the bus expects
    if (psel && penable && pwrite && pstrb[0] && paddr == cidr_pkg::OFS_SELECTOR) begin
      st_nxt.selector = pwdata[3:0];
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{selector: cidr_pkg::SEL_RESET, rdata: 32'h00000000, err: 1'b0,
                phase: cidr_pkg::PH_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready = 1'b1;  // zero-wait access
  assign prdata = (psel && penable) ? st_r.rdata : 32'h00000000;
  assign pslverr = psel && penable && st_r.err;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_boundary_code: assert property (@(posedge pclk) disable iff (!presetn)
    level_word.inner_boundary_level == 3'(1 + core_l2_built + cluster_l3_built))
    else $error("inner boundary code wrong");
  a_coherency_code: assert property (@(posedge pclk) disable iff (!presetn)
    level_word.coherency_level == level_word.inner_boundary_level)
    else $error("coherency level wrong");
  a_unify_zero: assert property (@(posedge pclk) disable iff (!presetn)
    level_word.uniproc_unify_level == 3'h0 && level_word.inner_share_unify_level == 3'h0
    && level_word[20:9] == 12'h000)
    else $error("unification or reserved bits nonzero");
  a_type_fields: assert property (@(posedge pclk) disable iff (!presetn)
    level_word.level_one_type == 3'h3 &&
    level_word.level_three_type == ((core_l2_built && cluster_l3_built) ? 3'h4 : 3'h0) &&
    level_word.level_two_type == ((core_l2_built || cluster_l3_built) ? 3'h4 : 3'h0))
    else $error("cache type fields wrong");
  a_aux_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == 12'h010) |=> (prdata == 32'h00000000))
    else $error("aux fault status not zero");
  a_size_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == 12'h004) |=> (prdata == $past(size_word)))
    else $error("size read mismatch");
  a_selector_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pstrb[0] && paddr == 12'h000) |=>
    (st_r.selector == $past(pwdata[3:0])))
    else $error("selector not updated");
  a_ident_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && paddr == 12'h004) |=> ($stable(st_r.selector) && !pslverr))
    else $error("identification write had effect");
  a_l1_line: assert property (@(posedge pclk) disable iff (!presetn)
    size_valid |-> size_word.line_bytes_log_code == 3'h2 && size_word.write_back_supported
    && size_word.read_alloc_supported && !size_word.write_through_supported)
    else $error("policy or line bits wrong");
  a_fallback_l2: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.selector == 4'h2 && !core_l2_built && cluster_l3_built) |->
    size_word.set_count_minus_one == 15'h03ff && size_word.ways_minus_one == 10'h00f)
    else $error("level two fallback wrong");
  a_wa_data: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.selector == 4'h0) |-> size_word.write_alloc_supported)
    else $error("write allocate wrong");

  c_size_read: cover property (@(posedge pclk) setup && !pwrite && paddr == 12'h004);
  c_sel_write: cover property (@(posedge pclk) setup && pwrite && paddr == 12'h000);
  c_unmapped: cover property (@(posedge pclk) pslverr);
  c_l3_sel: cover property (@(posedge pclk) st_r.selector == 4'h4 && size_valid);
endmodule

// ---- include/cidr_pkg.sv ----
package cidr_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses, our own placement)
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_SELECTOR = 12'h000;  // cache_selector, rw
  localparam logic [11:0] OFS_SIZE = 12'h004;  // cache_size_ident
  localparam logic [11:0] OFS_LEVEL_LO = 12'h008;  // cache_level_ident [31:0]
  localparam logic [11:0] OFS_LEVEL_HI = 12'h00c;  // cache_level_ident [63:32]
  localparam logic [11:0] OFS_AUX_FAULT = 12'h010;  // aux_fault_status_0_hyp
  localparam logic [11:0] OFS_CONFIG = 12'h014;  // build configuration, ro

  // ------------------------------------------------------------
  // selector field layout and codes
  // ------------------------------------------------------------
  localparam int SEL_IND_POS = 0;  // instruction/data selector bit
  localparam int SEL_LVL_LSB = 1;  // level code [3:1]
  localparam logic [2:0] LVL_ONE = 3'h0;
  localparam logic [2:0] LVL_TWO = 3'h1;
  localparam logic [2:0] LVL_THREE = 3'h2;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // ------------------------------------------------------------
  // cache size register fields
  // ------------------------------------------------------------
  localparam int SZ_WT_POS = 31;
  localparam int SZ_WB_POS = 30;
  localparam int SZ_RA_POS = 29;
  localparam int SZ_WA_POS = 28;
  localparam int SZ_SETS_LSB = 13;
  localparam int SZ_WAYS_LSB = 3;
  localparam int SZ_LINE_LSB = 0;

  // ------------------------------------------------------------
  // cache level register field codes
  // ------------------------------------------------------------
  localparam logic [2:0] BOUND_NONE = 3'h1;
  localparam logic [2:0] BOUND_ONE = 3'h2;
  localparam logic [2:0] BOUND_BOTH = 3'h3;
  localparam logic [2:0] UNIFY_NONE = 3'h0;
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_SPLIT = 3'h3;
  localparam logic [2:0] TYPE_UNIFIED = 3'h4;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic write_through_supported;
    logic write_back_supported;
    logic read_alloc_supported;
    logic write_alloc_supported;
    logic [14:0] set_count_minus_one;
    logic [9:0] ways_minus_one;
    logic [2:0] line_bytes_log_code;
  } cidr_size_t;

  typedef struct packed {
    logic [30:0] rsvd_hi;
    logic [2:0] inner_boundary_level;
    logic [2:0] uniproc_unify_level;
    logic [2:0] coherency_level;
    logic [2:0] inner_share_unify_level;
    logic [11:0] rsvd_upper_levels;
    logic [2:0] level_three_type;
    logic [2:0] level_two_type;
    logic [2:0] level_one_type;
  } cidr_level_t;

  typedef struct packed {
    logic core_l2;  // per-core second-level cache built
    logic cluster_l3;  // cluster cache built
  } cidr_cfg_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ACCESS
  } cidr_phase_t;
endpackage

// ---- src/cidr_size_lut.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// cache size word for the selected cache, fixed by build
// ------------------------------------------------------------
module cidr_size_lut (
  input wire logic [3:0] sel,
  input wire cidr_pkg::cidr_cfg_t cfg,
  output cidr_pkg::cidr_size_t word,
  output logic valid
);
  // per-level geometry pieces; values depend on built sizes
  localparam logic [14:0] L1_SETS = 15'h007f;
  localparam logic [14:0] L2_SETS = 15'h00ff;
  localparam logic [14:0] L3_SETS = 15'h03ff;
  localparam logic [9:0] L1_WAYS = 10'h003;
  localparam logic [9:0] L2_WAYS = 10'h003;
  localparam logic [9:0] L3_WAYS = 10'h00f;
  localparam logic [2:0] LINE_64 = 3'h2;  // 64-byte lines

  logic [2:0] lvl;
  logic ind;

  // level decode, cluster cache stands in for a missing level 2
  always_comb begin
    lvl = sel[cidr_pkg::SEL_LVL_LSB +: 3];
    ind = sel[cidr_pkg::SEL_IND_POS];
    word = '0;
    valid = 1'b0;
    word.write_back_supported = 1'b1;
    word.read_alloc_supported = 1'b1;
    word.write_alloc_supported = 1'b1;
    word.write_through_supported = 1'b0;
    word.line_bytes_log_code = LINE_64;
    case (lvl)
      cidr_pkg::LVL_ONE: begin
        valid = 1'b1;
        word.set_count_minus_one = L1_SETS;
        word.ways_minus_one = L1_WAYS;
        if (ind) begin
          word.write_alloc_supported = 1'b0;  // instruction side never writes
        end
      end
      cidr_pkg::LVL_TWO: begin
        valid = !ind && (cfg.core_l2 || cfg.cluster_l3);
        word.set_count_minus_one = cfg.core_l2 ? L2_SETS : L3_SETS;
        word.ways_minus_one = cfg.core_l2 ? L2_WAYS : L3_WAYS;
      end
      cidr_pkg::LVL_THREE: begin
        valid = !ind && cfg.core_l2 && cfg.cluster_l3;
        word.set_count_minus_one = L3_SETS;
        word.ways_minus_one = L3_WAYS;
      end
      default: begin
        valid = 1'b0;
      end
    endcase
    if (!valid) begin
      word = '0;  // reserved selection reads zero
    end
  end
endmodule

// ---- src/cidr_level_gen.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// cache level word from the built hierarchy
// ------------------------------------------------------------
module cidr_level_gen (
  input wire cidr_pkg::cidr_cfg_t cfg,
  output cidr_pkg::cidr_level_t word
);
  logic both;
  logic any;

  // all fields are configuration-fixed
  always_comb begin
    both = cfg.core_l2 && cfg.cluster_l3;
    any = cfg.core_l2 || cfg.cluster_l3;
    word = '0;
    word.inner_boundary_level = both ? cidr_pkg::BOUND_BOTH :
      (any ? cidr_pkg::BOUND_ONE : cidr_pkg::BOUND_NONE);
    word.coherency_level = word.inner_boundary_level;
    word.uniproc_unify_level = cidr_pkg::UNIFY_NONE;
    word.inner_share_unify_level = cidr_pkg::UNIFY_NONE;
    word.level_three_type = both ? cidr_pkg::TYPE_UNIFIED : cidr_pkg::TYPE_NONE;
    word.level_two_type = any ? cidr_pkg::TYPE_UNIFIED : cidr_pkg::TYPE_NONE;
    word.level_one_type = cidr_pkg::TYPE_SPLIT;
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // bench signals, all but rd, er and the DUT outputs given a value at time zero
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0; // active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic core_l2_built = 1'b0; // build straps, moved only in reset
  logic cluster_l3_built = 1'b0;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] rd; // last read word
  logic er; // last error flag

  cidr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_l2_built(core_l2_built),
    .cluster_l3_built(cluster_l3_built));

  // 200 MHz
  always #2.5 pclk = ~pclk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one apb transfer; an idle edge first keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready, bounded so a stuck slave cannot hang us
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // reset with a new strap setting; straps are static outside reset
  task automatic do_reset(input logic l2, input logic l3);
    @(posedge pclk);
    presetn <= 1'b0;
    core_l2_built <= l2;
    cluster_l3_built <= l3;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // expected size word, geometry as chosen for this build
  function automatic logic [31:0] exp_size(input logic [3:0] s, input logic l2,
    input logic l3);
    logic [14:0] sets;
    logic [9:0] ways;
    logic wa;
    logic ok;
    sets = 15'h0;
    ways = 10'h0;
    wa = 1'b1;
    ok = 1'b1;
    if (s[3:1] == 3'h0) begin
      sets = 15'h7f;
      ways = 10'h3;
      wa = ~s[0]; // instruction side does not write-allocate
    end else if (s[3:1] == 3'h1 && !s[0] && (l2 || l3)) begin
      // no core cache: cluster cache stands in as level two
      sets = l2 ? 15'hff : 15'h3ff;
      ways = l2 ? 10'h3 : 10'hf;
    end else if (s[3:1] == 3'h2 && !s[0] && l2 && l3) begin
      sets = 15'h3ff;
      ways = 10'hf;
    end else begin
      ok = 1'b0;
    end
    return ok ? {1'b0, 1'b1, 1'b1, wa, sets, ways, 3'h2} : 32'h0;
  endfunction

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // level register for the current build
  task automatic t_level(input logic l2, input logic l3);
    logic [2:0] lvl;
    logic [2:0] t2;
    logic [2:0] t3;
    lvl = 3'h1 + {2'h0, l2} + {2'h0, l3};
    t2 = (l2 || l3) ? 3'h4 : 3'h0;
    t3 = (l2 && l3) ? 3'h4 : 3'h0;
    apb(1'b0, cidr_pkg::OFS_LEVEL_LO, 32'h0);
    chk(rd, {lvl[1:0], 3'h0, lvl, 3'h0, 12'h0, t3, t2, 3'h3}, "level lo");
    apb(1'b0, cidr_pkg::OFS_LEVEL_HI, 32'h0);
    chk(rd, {31'h0, lvl[2]}, "level hi");
    apb(1'b0, cidr_pkg::OFS_CONFIG, 32'h0);
    chk(rd, {29'h0, 1'b1, l2, l3}, "config word");
    $display("test level l2=%b l3=%b done", l2, l3);
  endtask

  // every selector code, reserved ones included
  task automatic t_size(input logic l2, input logic l3);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, cidr_pkg::OFS_SELECTOR, {28'h0, 4'(i)});
      apb(1'b0, cidr_pkg::OFS_SIZE, 32'h0);
      chk(rd, exp_size(4'(i), l2, l3), "size word");
    end
    $display("test size l2=%b l3=%b done", l2, l3);
  endtask

  // writes to fixed words are dropped; aux word and holes read zero
  task automatic t_fixed();
    apb(1'b0, cidr_pkg::OFS_SELECTOR, 32'h0);
    chk(rd, {28'h0, cidr_pkg::SEL_RESET}, "selector reset");
    apb(1'b1, cidr_pkg::OFS_SIZE, 32'hffffffff);
    apb(1'b1, cidr_pkg::OFS_LEVEL_LO, 32'hffffffff);
    apb(1'b1, cidr_pkg::OFS_AUX_FAULT, 32'hffffffff);
    apb(1'b0, cidr_pkg::OFS_SIZE, 32'h0);
    chk(rd, exp_size(4'h0, 1'b1, 1'b1), "size after write");
    apb(1'b0, cidr_pkg::OFS_LEVEL_LO, 32'h0);
    chk(rd, 32'hc300_0123, "level after write");
    apb(1'b0, cidr_pkg::OFS_AUX_FAULT, 32'h0);
    chk(rd, 32'h0, "aux fault word");
    chk({31'h0, er}, 32'h0, "aux fault error");
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk({31'h0, pready}, 32'h1, "ready level");
    chk(rd, 32'h0, "unmapped data");
    $display("test fixed done");
  endtask

  // ------------------------------------------------------------
  // verdict, shared by the main sequence and the watchdog
  // ------------------------------------------------------------
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence: every strap combination
  initial begin
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1], c[0]);
      t_level(c[1], c[0]);
      t_size(c[1], c[0]);
    end
    do_reset(1'b1, 1'b1);
    t_fixed();
    final_report();
  end

  // watchdog, far beyond the fewer than 500 cycles the run needs
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule
